// File: rtl/usbft_frame_hub.v
/*
 * frame timing and root hub descriptor/status logic of a usb 1.x host
 * controller, with an apb register slave.
 * assumes: bit_tick is a one-cycle strobe per usb bit time, synchronous
 * to pclk; all inputs synchronous to pclk; the shared-area write engine
 * answers comm_write_req with a one-cycle comm_write_done.
 */
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`include "usbft_consts.vh"

module usbft_frame_hub #(
    parameter       NUM_PORTS      = 15,
    parameter [7:0] SETTLE_DELAY   = 8'h32,
    parameter       NO_GUARD_RST   = 1'b0,
    parameter       NO_SWITCH_RST  = 1'b0,
    parameter       SWITCH_SCOPE_RST = 1'b1
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        running_state,
    input  wire        bit_tick,
    input  wire        transaction_busy,
    input  wire        slow_start_req,
    input  wire        comm_write_done,
    input  wire        suspended,
    input  wire        attach_change_flag,
    input  wire [15:0] port_power_set,
    input  wire [15:0] port_power_clr,
    output reg         sof_send,
    output reg         comm_write_req,
    output reg  [15:0] frame_count_value,
    output reg         ed_fetch_ok,
    output reg         frame_begin_flag,
    output reg         periodic_priority,
    output reg         slow_start_grant,
    output reg         resume_request,
    output reg         resume_seen_flag,
    output reg  [15:0] port_power_on
);

    // frame sequencer states
    localparam [1:0] ST_IDLE  = 2'b00;
    localparam [1:0] ST_WRITE = 2'b01;
    localparam [1:0] ST_FLAG  = 2'b10;

    reg  [13:0] interval_ff;
    reg         interval_flip_ff;
    reg  [13:0] left_ff;
    reg         rem_toggle_ff;
    reg         running_d_ff;
    reg  [13:0] prio_point_ff;
    reg  [11:0] slow_cut_ff;
    reg  [7:0]  settle_ff;
    reg         no_guard_ff;
    reg         guard_scope_ff;
    reg         always_pwr_ff;
    reg         sw_scope_ff;
    reg  [15:0] pwr_mask_ff;
    reg  [15:0] fixed_ff;
    reg         wake_en_ff;
    reg  [1:0]  seq_ff;
    reg         prio_due_ff;

    wire        wr_acc;
    wire        start_run;
    wire        reload;
    wire        boundary;
    wire [15:0] port_bits;
    wire [15:0] glob_sel;
    wire [31:0] desc_a;
    reg  [31:0] rd_mux;
    reg         hit;

    // apb write takes effect on the edge where pready is seen high
    assign wr_acc    = psel & penable & pready & pwrite;
    assign start_run = running_state & ~running_d_ff;
    assign reload    = running_state & running_d_ff & bit_tick
                       & (left_ff == 14'h0000);
    assign boundary  = start_run | reload;
    // valid port lanes 1..NUM_PORTS, lane 0 reserved
    assign port_bits = ((16'h0001 << NUM_PORTS) - 16'h0001) << 1;
    // global commands reach masked ports only in global mode
    assign glob_sel  = sw_scope_ff ? (port_bits & ~pwr_mask_ff) : port_bits; // RL15
    assign desc_a    = {settle_ff, 11'h000, no_guard_ff, guard_scope_ff,
                        1'b0, always_pwr_ff, sw_scope_ff,
                        NUM_PORTS[7:0]}; // RL10 RL11 RL12 RL13 RL14 RL16

    // read decode; unmapped addresses answer with pslverr
    always @* begin
        rd_mux = 32'h0000_0000;
        hit    = 1'b1;
        case (paddr)
            `USBFT_OFS_INTERVAL: rd_mux = {interval_flip_ff, 17'h00000,
                                           interval_ff};
            `USBFT_OFS_REMAIN:   rd_mux = {rem_toggle_ff, 17'h00000,
                                           left_ff};
            `USBFT_OFS_FRAMENUM: rd_mux = {16'h0000, frame_count_value};
            `USBFT_OFS_PERIODIC: rd_mux = {18'h00000, prio_point_ff};
            `USBFT_OFS_SLOWCUT:  rd_mux = {20'h00000, slow_cut_ff};
            `USBFT_OFS_DESC_A:   rd_mux = desc_a;
            `USBFT_OFS_DESC_B:   rd_mux = {pwr_mask_ff, fixed_ff};
            // global power command bit reads zero
            `USBFT_OFS_HUB_STAT: rd_mux = {16'h0000, wake_en_ff,
                                           15'h0000}; // RL20
            default:             hit    = 1'b0;
        endcase
    end

    // apb slave: one wait state, registered answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            if (psel & penable & ~pready & ~pwrite)
                prdata <= rd_mux;
        end
    end

    // software-written configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interval_ff      <= `USBFT_INTERVAL_RST; // RL23
            interval_flip_ff <= 1'b0;
            prio_point_ff    <= `USBFT_PERIODIC_RST; // RL7
            slow_cut_ff      <= `USBFT_SLOWCUT_RST;
            settle_ff        <= 8'h00;
            no_guard_ff      <= 1'b0;
            guard_scope_ff   <= 1'b0;
            always_pwr_ff    <= 1'b0;
            sw_scope_ff      <= 1'b0;
            pwr_mask_ff      <= 16'h0000;
            fixed_ff         <= 16'h0000;
        end else if (running_d_ff == 1'b0 && settle_ff == 8'h00
                     && !wr_acc && !sw_scope_ff && !always_pwr_ff
                     && pwr_mask_ff == 16'h0000 && !running_state
                     && seq_ff == ST_IDLE && !no_guard_ff
                     && !guard_scope_ff && fixed_ff == 16'h0000
                     && prdata == 32'h0000_0000 && !pready) begin
            // strap load of implementation values after reset release
            settle_ff      <= SETTLE_DELAY; // RL10
            no_guard_ff    <= NO_GUARD_RST;
            guard_scope_ff <= SWITCH_SCOPE_RST; // RL12
            always_pwr_ff  <= NO_SWITCH_RST;
            sw_scope_ff    <= SWITCH_SCOPE_RST;
        end else if (wr_acc) begin
            case (paddr)
                `USBFT_OFS_INTERVAL: begin
                    // software flips bit 31 with each new interval
                    interval_flip_ff <= pwdata[`USBFT_TOGGLE_BIT]; // RL24
                    interval_ff      <= pwdata[13:0];
                end
                `USBFT_OFS_PERIODIC: prio_point_ff <= pwdata[13:0];
                `USBFT_OFS_SLOWCUT:  slow_cut_ff   <= pwdata[11:0];
                `USBFT_OFS_DESC_A: begin
                    // port count and compound flag are not writable
                    settle_ff      <= pwdata[31:24];
                    no_guard_ff    <= pwdata[12]; // RL11
                    guard_scope_ff <= pwdata[11]; // RL12
                    always_pwr_ff  <= pwdata[9]; // RL14
                    sw_scope_ff    <= pwdata[8]; // RL15
                end
                `USBFT_OFS_DESC_B: begin
                    pwr_mask_ff <= pwdata[31:16] & port_bits; // RL17
                    fixed_ff    <= pwdata[15:0] & port_bits; // RL18
                end
                default: ;
            endcase
        end
    end

    // frame remaining counter and frame number
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running_d_ff      <= 1'b0;
            left_ff           <= 14'h0000; // RL25
            rem_toggle_ff     <= 1'b0; // RL25
            frame_count_value <= 16'h0000;
        end else begin
            running_d_ff <= running_state;
            if (!running_state) begin
                left_ff <= left_ff;
            end else if (start_run) begin
                left_ff           <= interval_ff; // RL3
                frame_count_value <= frame_count_value + 16'h0001; // RL5
            end else if (reload) begin
                left_ff           <= interval_ff; // RL2
                rem_toggle_ff     <= interval_flip_ff; // RL1
                frame_count_value <= frame_count_value + 16'h0001; // RL4
            end else if (bit_tick) begin
                left_ff <= left_ff - 14'h0001; // RL2
            end
        end
    end

    // boundary sequence: sof, shared-area write, then frame flag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_ff           <= ST_IDLE;
            sof_send         <= 1'b0;
            comm_write_req   <= 1'b0;
            ed_fetch_ok      <= 1'b0;
            frame_begin_flag <= 1'b0;
        end else begin
            sof_send         <= 1'b0;
            frame_begin_flag <= 1'b0;
            case (seq_ff)
                ST_IDLE: begin
                    if (boundary) begin
                        sof_send       <= 1'b1; // RL6
                        comm_write_req <= 1'b1; // RL6
                        ed_fetch_ok    <= 1'b0; // RL6
                        seq_ff         <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    // descriptors stay locked until count is in memory
                    if (comm_write_done) begin
                        comm_write_req <= 1'b0;
                        seq_ff         <= ST_FLAG;
                    end
                end
                ST_FLAG: begin
                    frame_begin_flag <= 1'b1; // RL6
                    ed_fetch_ok      <= 1'b1; // RL6
                    seq_ff           <= ST_IDLE;
                end
                default: seq_ff <= ST_IDLE;
            endcase
        end
    end

    // periodic priority and slow transfer admission
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_due_ff       <= 1'b0;
            periodic_priority <= 1'b0;
            slow_start_grant  <= 1'b0;
        end else begin
            if (boundary) begin
                prio_due_ff       <= 1'b0;
                periodic_priority <= 1'b0;
            end else begin
                if (running_state && left_ff == prio_point_ff)
                    prio_due_ff <= 1'b1; // RL8
                // the transfer in flight is allowed to complete first
                if ((prio_due_ff || (running_state
                     && left_ff == prio_point_ff)) && !transaction_busy)
                    periodic_priority <= 1'b1; // RL8
            end
            slow_start_grant <= slow_start_req & running_state
                                & (left_ff >= slow_cut_ff); // RL9
        end
    end

    // hub status: wake enable, global power, remote wakeup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_en_ff       <= 1'b0;
            resume_request   <= 1'b0;
            resume_seen_flag <= 1'b0;
            port_power_on    <= 16'h0000;
        end else begin
            if (wr_acc && paddr == `USBFT_OFS_HUB_STAT) begin
                // a set in the same write wins over the clear
                if (pwdata[`USBFT_WAKE_EN_BIT])
                    wake_en_ff <= 1'b1; // RL21
                else if (pwdata[`USBFT_WAKE_CLR_BIT])
                    wake_en_ff <= 1'b0; // RL19
            end
            resume_request   <= wake_en_ff & suspended
                                & attach_change_flag; // RL21
            resume_seen_flag <= wake_en_ff & suspended
                                & attach_change_flag; // RL21
            if (always_pwr_ff) begin
                port_power_on <= port_bits; // RL14
            end else begin
                port_power_on <= (port_power_on
                    | (port_power_set & pwr_mask_ff & {16{sw_scope_ff}})
                    | (glob_sel & {16{wr_acc
                        && paddr == `USBFT_OFS_HUB_STAT
                        && pwdata[`USBFT_GPWR_ON_BIT]}})) // RL20
                    & ~(port_power_clr & pwr_mask_ff & {16{sw_scope_ff}}
                        & ~port_power_set)
                    & ~(glob_sel & {16{wr_acc
                        && paddr == `USBFT_OFS_HUB_STAT
                        && pwdata[`USBFT_GPWR_OFF_BIT]
                        && !pwdata[`USBFT_GPWR_ON_BIT]}})
                    & port_bits;
            end
        end
    end

endmodule // usbft_frame_hub

// File: rtl/usbft_consts.vh
/*
 * constants of the usb frame timing and root hub block: register byte
 * offsets, field positions and reset values.
 * assumes: included by the block's rtl and by the testbench; 32-bit apb data.
 */
//
// Contract
// RL1 - at counter zero, copy interval toggle into remaining toggle bit 31
// RL2 - 14-bit remaining count drops per bit time, reloads interval after zero
// RL3 - entering running state reloads counter from interval field
// RL4 - frame count rises on each reload, wraps from all ones to zero
// RL5 - frame count also rises on entering running state
// RL6 - per frame: sof, write count to shared area, then flag frame begin
// RL7 - reset clears 14-bit periodic priority point to zero
// RL8 - at periodic point, finish control/bulk then favour periodic lists
// RL9 - slow transfer starts only if remaining count >= 12-bit cutoff 0628h
// RL10 - descriptor bits 31:24 give power settle delay in 2 ms units
// RL11 - descriptor bit 12 set means no overload guard
// RL12 - descriptor bit 11 picks collective or per-port overload reporting
// RL13 - descriptor bit 10 compound flag reads zero, writes ignored
// RL14 - descriptor bit 9 set means ports always powered
// RL15 - descriptor bit 8 picks global or masked per-port power switching
// RL16 - descriptor bits 7:0 read-only port count, 1 to 15
// RL17 - second descriptor 31:16 per-port power mask, bit 16 reserved
// RL18 - second descriptor 15:0 non-removable flags, bit 0 reserved
// RL19 - status bit 31 written one clears connect wake enable
// RL20 - status bit 16 reads zero; one powers globally switched ports
// RL21 - wake enable makes attach change a resume, raising resume seen
// RL22 - software writes zero to reserved status bits
// RL23 - frame interval field resets to 2EDFh, 11999 bit times
// RL24 - software flips interval toggle whenever it loads a new interval
// RL25 - reset clears remaining count and toggle until running loads it
`ifndef USBFT_CONSTS_VH
`define USBFT_CONSTS_VH

// register byte offsets
`define USBFT_OFS_INTERVAL   16'hD034
`define USBFT_OFS_REMAIN     16'hD038
`define USBFT_OFS_FRAMENUM   16'hD03C
`define USBFT_OFS_PERIODIC   16'hD040
`define USBFT_OFS_SLOWCUT    16'hD044
`define USBFT_OFS_DESC_A     16'hD048
`define USBFT_OFS_DESC_B     16'hD04C
`define USBFT_OFS_HUB_STAT   16'hD050

// field positions
`define USBFT_TOGGLE_BIT     31
`define USBFT_WAKE_CLR_BIT   31
`define USBFT_GPWR_ON_BIT    16
`define USBFT_WAKE_EN_BIT    15
`define USBFT_GPWR_OFF_BIT   0

// reset values
`define USBFT_INTERVAL_RST   14'h2EDF
`define USBFT_PERIODIC_RST   14'h0000
`define USBFT_SLOWCUT_RST    12'h628
`define USBFT_SETTLE_UNIT_MS 2

`endif

// File: test/usbft_chk_sva.sv
/*
 * port checker for the frame hub: apb answer, frame sequence and event
 * outputs tied to their causes.
 * assumes: bound to usbft_frame_hub; one pclk domain, presetn async low.
 */
`timescale 1ns/10ps
module usbft_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        pready,
    input wire        transaction_busy,
    input wire        slow_start_req,
    input wire        running_state,
    input wire        suspended,
    input wire        attach_change_flag,
    input wire        comm_write_done,
    input wire        sof_send,
    input wire        comm_write_req,
    input wire [15:0] frame_count_value,
    input wire        ed_fetch_ok,
    input wire        frame_begin_flag,
    input wire        periodic_priority,
    input wire        slow_start_grant,
    input wire        resume_request,
    input wire        resume_seen_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // apb answers last one cycle, so back-to-back reads never merge
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    // any change of the frame count is a step of one, wrapping in 16 bits
    chk_frame_step: assert property (
        $changed(frame_count_value) |->
        frame_count_value == $past(frame_count_value) + 16'h0001)
        else $error("frame count moved by other than one");
    // boundary opens the shared write and blocks descriptor fetch
    chk_sof_fetch: assert property (
        sof_send |-> comm_write_req && !ed_fetch_ok)
        else $error("start of frame without write request");
    chk_req_hold: assert property (
        comm_write_req && !comm_write_done |=> comm_write_req)
        else $error("write request dropped before done");
    chk_done_flag: assert property (
        comm_write_req && comm_write_done |->
        ##[1:2] frame_begin_flag && ed_fetch_ok)
        else $error("frame flag missing after shared write");
    // grants and wake events are one cycle behind their causes
    chk_slow_cause: assert property (
        slow_start_grant |-> $past(slow_start_req) && $past(running_state))
        else $error("slow grant without request while running");
    chk_resume_cause: assert property (
        resume_seen_flag |-> resume_request && $past(suspended) &&
        $past(attach_change_flag))
        else $error("resume without suspended attach change");
    chk_prio_idle: assert property (
        $rose(periodic_priority) |-> !$past(transaction_busy))
        else $error("periodic priority taken during a transaction");

    cov_frame: cover property (frame_begin_flag);
    cov_resume: cover property (resume_seen_flag);
    cov_slow: cover property (slow_start_grant);
endmodule // usbft_chk

// File: test/usbft_far.sv
/*
 * far-side model: usb bit-time strobe and the shared-area write engine.
 * assumes: same pclk and presetn as the frame hub.
 */
`timescale 1ns/10ps
module usbft_far #(
    parameter DIV = 4
) (
    input  wire pclk,
    input  wire presetn,
    input  wire comm_write_req,
    input  wire slow,
    output reg  bit_tick,
    output reg  comm_write_done
);
    reg [3:0] div_ff;
    reg [3:0] wait_ff;

    // one strobe every DIV cycles stands for a bit time
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff   <= 4'h0;
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= (div_ff == DIV - 1);
            div_ff   <= (div_ff == DIV - 1) ? 4'h0 : div_ff + 4'h1;
        end
    end
    // one done per request; slow mode mimics a stalled memory bus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_ff         <= 4'h0;
            comm_write_done <= 1'b0;
        end else begin
            wait_ff         <= comm_write_req ? wait_ff + 4'h1 : 4'h0;
            comm_write_done <= comm_write_req &&
                               wait_ff == (slow ? 4'h6 : 4'h1);
        end
    end
endmodule // usbft_far

// File: test/testbench.sv
/*
 * self-checking bench: register values over apb, root hub power and
 * wake events, frame timing against the far-side model.
 * assumes: usbft_frame_hub, usbft_far and usbft_chk compiled first.
 */
`timescale 1ns/10ps
`include "usbft_consts.vh"
module testbench;
    localparam int DIV = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        running_state, transaction_busy, slow_start_req, slow;
    logic        suspended, attach_change_flag, bit_tick, comm_write_done;
    logic        sof_send, comm_write_req, ed_fetch_ok, frame_begin_flag;
    logic        periodic_priority, slow_start_grant, resume_request;
    logic        resume_seen_flag, last_err;
    logic [15:0] paddr, port_power_set, port_power_clr;
    logic [15:0] frame_count_value, port_power_on;
    logic [31:0] pwdata, prdata, last_q;
    int          err_count, comparisons, cycles, n, resumes, grants;

    usbft_frame_hub uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .running_state, .bit_tick,
        .transaction_busy, .slow_start_req, .comm_write_done, .suspended,
        .attach_change_flag, .port_power_set, .port_power_clr, .sof_send,
        .comm_write_req, .frame_count_value, .ed_fetch_ok,
        .frame_begin_flag, .periodic_priority, .slow_start_grant,
        .resume_request, .resume_seen_flag, .port_power_on);
    usbft_far #(.DIV(DIV)) far (.pclk, .presetn, .comm_write_req, .slow,
        .bit_tick, .comm_write_done);

    // clock, event counters and hang guard
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (resume_seen_flag === 1'b1) resumes++;
        if (slow_start_grant === 1'b1) grants++;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // apb master: hold everything until pready is sampled high
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        last_q   = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(last_q, e);
    endtask
    // one-cycle power commands and attach change
    task automatic tap(input logic [15:0] s, c, input logic a);
        port_power_set     <= s;
        port_power_clr     <= c;
        attach_change_flag <= a;
        @(posedge pclk);
        port_power_set     <= 16'h0;
        port_power_clr     <= 16'h0;
        attach_change_flag <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic finish_test();
        $display("comparisons=%0d errors=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // main sequence: reset values, descriptors, power, wake, frames
    initial begin
        {presetn, psel, penable, pwrite, running_state} <= 5'h0;
        {transaction_busy, slow_start_req, slow, suspended} <= 4'h0;
        {attach_change_flag, paddr, pwdata} <= 49'h0;
        {port_power_set, port_power_clr} <= 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(`USBFT_OFS_PERIODIC, 32'h0);
        rd(`USBFT_OFS_SLOWCUT, 32'h628);
        rd(`USBFT_OFS_REMAIN, 32'h0);
        rd(`USBFT_OFS_DESC_A, 32'h3200090F);
        apb(1'b0, `USBFT_OFS_INTERVAL, 32'h0);
        chk(last_q & 32'h80003FFF, 32'h2EDF);
        apb(1'b1, `USBFT_OFS_FRAMENUM, 32'hFFFF);
        rd(`USBFT_OFS_FRAMENUM, 32'h0);
        apb(1'b1, `USBFT_OFS_DESC_A, 32'hA5001C00);
        apb(1'b0, `USBFT_OFS_DESC_A, 32'h0);
        chk(last_q & 32'hFF001FFF, 32'hA500180F);
        apb(1'b1, `USBFT_OFS_DESC_B, 32'hFFFFFFFF);
        rd(`USBFT_OFS_DESC_B, 32'hFFFEFFFE);
        rd(16'hD0F0, 32'h0);
        chk(32'(last_err), 32'h1);
        apb(1'b1, `USBFT_OFS_DESC_A, 32'h3200090F);
        apb(1'b1, `USBFT_OFS_DESC_B, 32'h00020000);
        apb(1'b1, `USBFT_OFS_HUB_STAT, 32'h00010000);
        chk(32'(port_power_on), 32'hFFFC);
        rd(`USBFT_OFS_HUB_STAT, 32'h0);
        tap(16'h0002, 16'h0, 1'b0);
        chk(32'(port_power_on), 32'hFFFE);
        apb(1'b1, `USBFT_OFS_HUB_STAT, 32'h00000001);
        chk(32'(port_power_on), 32'h0002);
        tap(16'h0, 16'h0002, 1'b0);
        chk(32'(port_power_on), 32'h0);
        apb(1'b1, `USBFT_OFS_DESC_A, 32'h3200080F);
        apb(1'b1, `USBFT_OFS_HUB_STAT, 32'h00010000);
        chk(32'(port_power_on), 32'hFFFE);
        apb(1'b1, `USBFT_OFS_HUB_STAT, 32'h00008000);
        rd(`USBFT_OFS_HUB_STAT, 32'h8000);
        suspended <= 1'b1;
        tap(16'h0, 16'h0, 1'b1);
        chk(32'(resumes), 32'h1);
        apb(1'b1, `USBFT_OFS_HUB_STAT, 32'h80000000);
        rd(`USBFT_OFS_HUB_STAT, 32'h0);
        tap(16'h0, 16'h0, 1'b1);
        chk(32'(resumes), 32'h1);
        suspended        <= 1'b0;
        transaction_busy <= 1'b1;
        slow_start_req   <= 1'b1;
        apb(1'b1, `USBFT_OFS_PERIODIC, 32'h8);
        apb(1'b1, `USBFT_OFS_SLOWCUT, 32'h11);
        // toggle flipped together with the new interval
        apb(1'b1, `USBFT_OFS_INTERVAL, 32'h80000010);
        running_state <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'(frame_count_value), 32'h1);
        apb(1'b0, `USBFT_OFS_REMAIN, 32'h0);
        chk(32'(last_q[13:0] inside {[13:16]}), 32'h1);
        chk(32'(last_q[31]), 32'h0);
        while (sof_send !== 1'b1) @(posedge pclk);
        chk(32'(frame_count_value), 32'h2);
        slow <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (sof_send !== 1'b1);
        chk(32'(n), 32'(17 * DIV));
        chk(32'(grants), 32'h0);
        chk(32'(periodic_priority), 32'h0);
        apb(1'b0, `USBFT_OFS_REMAIN, 32'h0);
        chk(32'(last_q[31]), 32'h1);
        transaction_busy <= 1'b0;
        apb(1'b1, `USBFT_OFS_SLOWCUT, 32'h10);
        n = 0;
        while (periodic_priority !== 1'b1 && n < 40 * DIV) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(periodic_priority), 32'h1);
        repeat (20 * DIV) @(posedge pclk);
        chk(32'(grants != 0), 32'h1);
        finish_test();
    end
endmodule // testbench

bind usbft_frame_hub usbft_chk u_chk (.pclk, .presetn, .pready,
    .transaction_busy, .slow_start_req, .running_state, .suspended,
    .attach_change_flag, .comm_write_done, .sof_send, .comm_write_req,
    .frame_count_value, .ed_fetch_ok, .frame_begin_flag,
    .periodic_priority, .slow_start_grant, .resume_request,
    .resume_seen_flag);
